// >>> rtl/irq_return_and_config_load_decode.sv
/*
 * Decode and execute of no-operation, return-from-interrupt and the
 * legacy timer configuration load, with the program counter, the global
 * interrupt enable bit and the timer configuration register.
 * Assumes program memory presents the word at PC_O and holds it through
 * Q1; the stack, status flags and other opcodes live elsewhere.
 */
// Functional notes
// RULE1: Return pops stack, loads PC, flags untouched.
// RULE2: Return sets interrupt enable, control bit 7.
// RULE3: Return: Q3 enable, Q4 pop, then idle cycle.
// RULE4: Config-load copies accumulator into config, one cycle.
// RULE5: Config register also file-readable and file-writable.
// RULE6: No-operation ignores don't-cares, only advances PC.
`timescale 1ns/1ps
`include "irq_ret_params.svh"

module irq_return_and_config_load_decode (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic [13:0] INSTR_I,
    input  wire logic [12:0] STACK_TOP_I,
    input  wire logic [7:0]  W_I,
    input  wire logic        IRQ_EN_CLR_I,
    input  wire logic        CFG_FILE_WE_I,
    input  wire logic [7:0]  CFG_FILE_WDATA_I,
    output logic [12:0]      PC_O,
    output logic             STACK_POP_O,
    output logic [7:0]       INTERRUPT_CONTROL_REG_O,
    output logic [7:0]       CFG_FILE_RDATA_O,
    output logic [1:0]       Q_PHASE_O
);

    // =====================================================================
    // Decode function
    // =====================================================================
    function automatic irq_ret_pkg::decode_s decode_word(input logic [13:0] w);
        irq_ret_pkg::decode_s d;
        // RULE6: don't-care bits masked
        d.is_nop      = ((w & `NOP_CARE_MASK) == `OPC_NOP);
        d.is_retfi    = (w == `OPC_RETFI);
        d.is_cfg_load = (w == `OPC_CFG_LOAD);
        return d;
    endfunction

    irq_ret_pkg::q_phase_e phase;
    logic                  tick;

    q_phase_gen u_phase (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RST_I),
        .phase_o (phase),
        .tick_o  (tick)
    );

    logic [13:0]          ir_ff;
    logic [13:0]          nxt_ir;
    logic [12:0]          pc_ff;
    logic [12:0]          nxt_pc;
    logic                 irq_en_ff;
    logic                 nxt_irq_en;
    logic [7:0]           cfg_ff;
    logic [7:0]           nxt_cfg;
    logic                 flush_ff;
    logic                 nxt_flush;
    logic                 pop_ff;
    logic                 nxt_pop;
    irq_ret_pkg::decode_s dec;
    logic                 exec;
    logic                 q3_tick;
    logic                 q4_tick;

    // =====================================================================
    // Execute
    // =====================================================================
    always_comb begin
        dec        = decode_word(ir_ff);
        // Second cycle of a return executes nothing from the stale word
        exec       = !flush_ff;
        q3_tick    = tick && (phase == irq_ret_pkg::Q3);
        q4_tick    = tick && (phase == irq_ret_pkg::Q4);
        nxt_ir     = ir_ff;
        nxt_pc     = pc_ff;
        nxt_irq_en = irq_en_ff;
        nxt_cfg    = cfg_ff;
        nxt_flush  = flush_ff;
        nxt_pop    = 1'b0;

        if (tick && phase == irq_ret_pkg::Q1) begin
            nxt_ir = INSTR_I;
        end

        // RULE2: set wins over clear
        if (IRQ_EN_CLR_I) begin
            nxt_irq_en = 1'b0;
        end
        // RULE3: enable set in Q3
        if (q3_tick && exec && dec.is_retfi) begin
            nxt_irq_en = 1'b1;
        end

        // RULE5: file write path
        if (CFG_FILE_WE_I) begin
            nxt_cfg = CFG_FILE_WDATA_I;
        end
        // RULE4: accumulator load, wins over a file write in the same cycle
        if (q4_tick && exec && dec.is_cfg_load) begin
            nxt_cfg = W_I;
        end

        if (q4_tick) begin
            nxt_flush = 1'b0;
            // RULE1: pop stack into PC
            if (exec && dec.is_retfi) begin
                nxt_pc    = STACK_TOP_I;
                nxt_pop   = 1'b1;
                nxt_flush = 1'b1;
            end else begin
                // RULE6: plain advance
                nxt_pc = pc_ff + 13'h0001;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ir_ff     <= `IR_RST;
            pc_ff     <= `PC_RST;
            irq_en_ff <= 1'b0;
            cfg_ff    <= `CFG_RST;
            flush_ff  <= 1'b0;
            pop_ff    <= 1'b0;
        end else begin
            ir_ff     <= nxt_ir;
            pc_ff     <= nxt_pc;
            irq_en_ff <= nxt_irq_en;
            cfg_ff    <= nxt_cfg;
            flush_ff  <= nxt_flush;
            pop_ff    <= nxt_pop;
        end
    end

    always_comb begin
        INTERRUPT_CONTROL_REG_O                 = 8'h00;
        INTERRUPT_CONTROL_REG_O[`IRQ_EN_BIT]    = irq_en_ff;
    end

    assign PC_O             = pc_ff;
    assign STACK_POP_O      = pop_ff;
    assign CFG_FILE_RDATA_O = cfg_ff;
    assign Q_PHASE_O        = phase;

    // =====================================================================
    // Assertions
    // =====================================================================
    localparam int PhaseGap = `PHASE_CYC;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    sequence s_ret_q3;
        q3_tick && exec && dec.is_retfi;
    endsequence

    sequence s_pop_then_idle;
        STACK_POP_O ##1 (flush_ff && !STACK_POP_O);
    endsequence

    a_pop_loads_pc: assert property ( // RULE1
        q4_tick && exec && dec.is_retfi |=> PC_O == $past(STACK_TOP_I) && STACK_POP_O)
        else $error("return did not load stack top into PC");

    a_irq_en_set: assert property ( // RULE2
        s_ret_q3 |=> INTERRUPT_CONTROL_REG_O[`IRQ_EN_BIT])
        else $error("return did not set interrupt enable");

    a_ret_step_order: assert property ( // RULE3
        s_ret_q3 |-> ##PhaseGap ##1 s_pop_then_idle)
        else $error("return pop not one phase after enable set");

    a_idle_no_pop: assert property ( // RULE3
        flush_ff && q4_tick |=> !STACK_POP_O && !flush_ff && PC_O == $past(PC_O) + 13'h0001)
        else $error("second return cycle did not idle");

    a_cfg_from_acc: assert property ( // RULE4
        q4_tick && exec && dec.is_cfg_load |=> CFG_FILE_RDATA_O == $past(W_I))
        else $error("config load did not copy accumulator");

    a_cfg_file_write: assert property ( // RULE5
        CFG_FILE_WE_I && !(q4_tick && exec && dec.is_cfg_load)
        |=> CFG_FILE_RDATA_O == $past(CFG_FILE_WDATA_I))
        else $error("file write to config register lost");

    a_nop_advance: assert property ( // RULE6
        q4_tick && exec && dec.is_nop && !CFG_FILE_WE_I && !IRQ_EN_CLR_I
        |=> PC_O == $past(PC_O) + 13'h0001 && $stable(CFG_FILE_RDATA_O)
            && $stable(INTERRUPT_CONTROL_REG_O) && !STACK_POP_O)
        else $error("no-operation changed state");

    a_pc_hold_mid: assert property ( // RULE6
        !q4_tick |=> $stable(PC_O))
        else $error("PC moved outside Q4");

    a_pop_one_shot: assert property ( // RULE1
        STACK_POP_O |=> !STACK_POP_O)
        else $error("stack pop held longer than one cycle");

    a_irq_en_clear: assert property ( // RULE2
        IRQ_EN_CLR_I && !(q3_tick && exec && dec.is_retfi)
        |=> !INTERRUPT_CONTROL_REG_O[`IRQ_EN_BIT])
        else $error("interrupt enable clear lost");

    a_idle_no_effect: assert property ( // RULE3
        flush_ff && !CFG_FILE_WE_I && !IRQ_EN_CLR_I
        |=> $stable(CFG_FILE_RDATA_O) && $stable(INTERRUPT_CONTROL_REG_O))
        else $error("word in second return cycle took effect");

    a_phase_wrap: assert property ( // RULE3
        q4_tick |=> Q_PHASE_O == 2'h0)
        else $error("phase did not wrap from Q4 to Q1");

    a_phase_hold: assert property ( // RULE3
        !tick |=> $stable(Q_PHASE_O))
        else $error("phase moved without a tick");

endmodule

// >>> rtl/irq_ret_params.svh
/*
 * Constants for the return-from-interrupt and configuration-load decoder:
 * opcodes, field positions, reset values and phase timing.
 * Assumes a 20 MHz system clock and a 14-bit instruction word.
 */
`ifndef IRQ_RET_PARAMS_SVH
`define IRQ_RET_PARAMS_SVH

// =========================================================================
// Opcodes
// =========================================================================
`define OPC_RETFI        14'h0009
`define OPC_CFG_LOAD     14'h0062
`define OPC_NOP          14'h0000
// Bits 5 and 6 of the no-operation word are don't-care
`define NOP_CARE_MASK    14'h3f9f

// =========================================================================
// Fields and reset values
// =========================================================================
`define IRQ_EN_BIT       7
`define PC_RST           13'h0000
`define CFG_RST          8'hff
`define IR_RST           14'h0000

// =========================================================================
// Timing
// =========================================================================
`define CLK_MHZ          20
`define PHASE_NS         100
`define PHASE_CYC        ((`PHASE_NS * `CLK_MHZ) / 1000)

`endif

// >>> rtl/irq_ret_pkg.sv
/*
 * Types shared by the decoder and its phase generator.
 * Assumes the constants header is included by the design files.
 */
package irq_ret_pkg;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } q_phase_e;

    typedef struct packed {
        logic is_nop;
        logic is_retfi;
        logic is_cfg_load;
    } decode_s;

endpackage

// >>> rtl/q_phase_gen.sv
/*
 * Four-phase instruction clock generator: a divider makes a one-cycle
 * phase tick, and the phase steps Q1..Q4 on each tick.
 * Assumes one system clock; no other domain.
 */
`timescale 1ns/1ps
`include "irq_ret_params.svh"

module q_phase_gen (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    output irq_ret_pkg::q_phase_e     phase_o,
    output logic                      tick_o
);

    localparam logic [3:0] DivLast = 4'(`PHASE_CYC - 1);

    logic [3:0]            div_ff;
    logic [3:0]            nxt_div;
    irq_ret_pkg::q_phase_e phase_ff;
    irq_ret_pkg::q_phase_e nxt_phase;

    // =====================================================================
    // Divider and phase sequence
    // =====================================================================
    always_comb begin
        tick_o    = (div_ff == DivLast);
        nxt_div   = tick_o ? 4'h0 : div_ff + 4'h1;
        nxt_phase = phase_ff;
        if (tick_o) begin
            case (phase_ff)
                irq_ret_pkg::Q1: nxt_phase = irq_ret_pkg::Q2;
                irq_ret_pkg::Q2: nxt_phase = irq_ret_pkg::Q3;
                irq_ret_pkg::Q3: nxt_phase = irq_ret_pkg::Q4;
                irq_ret_pkg::Q4: nxt_phase = irq_ret_pkg::Q1;
                default:         nxt_phase = irq_ret_pkg::Q1;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff   <= 4'h0;
            phase_ff <= irq_ret_pkg::Q1;
        end else begin
            div_ff   <= nxt_div;
            phase_ff <= nxt_phase;
        end
    end

    assign phase_o = phase_ff;

endmodule

// >>> tb/prog_mem_model.sv
/*
 * Program memory model: a small fixed program read without delay at the
 * address the core drives.
 * Assumes the core samples the word at its own phase tick.
 */
`timescale 1ns/1ps
`include "irq_ret_params.svh"

module prog_mem_model (
    input  wire logic [12:0] addr_i,
    output logic [13:0]      instr_o
);
    logic [13:0] mem [0:15];

    // =====================================================================
    // Program
    // =====================================================================
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = `OPC_NOP;
        end
        // Don't-care bits set, so the decoder must mask them
        mem[0]  = 14'h0060;
        mem[1]  = `OPC_CFG_LOAD;
        mem[2]  = `OPC_RETFI;
        // Fetched in the idle cycle after the return; must have no effect
        mem[10] = `OPC_CFG_LOAD;
        // Second return, run while the enable clear is held
        mem[12] = `OPC_RETFI;
    end

    // Out of range shows an all-ones word instead of a stale one
    assign instr_o = (addr_i < 13'h0010) ? mem[addr_i[3:0]] : 14'h3fff;
endmodule

// >>> tb/irq_return_and_config_load_decode_tb.sv
/*
 * Self-checking bench: runs the fixed program through the decoder and
 * checks PC, pops, enable timing and the configuration register.
 * Assumes the design's 8-clock instruction cycle and phase output.
 */
`timescale 1ns/1ps
`include "irq_ret_params.svh"

module irq_return_and_config_load_decode_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [13:0] instr;
    logic [12:0] stack_top = 13'h000a;
    logic [7:0]  w_acc = 8'h5a;
    logic        en_clr = 1'b0;
    logic        file_we = 1'b0;
    logic [7:0]  file_wdata = 8'h00;
    logic [12:0] pc;
    logic        pop;
    logic [7:0]  icr;
    logic [7:0]  cfg;
    logic [1:0]  phase;
    logic [7:0]  en_q2, en_q3;
    int          pops, n_mismatch = 0, num_checks = 0, cyc = 0;

    irq_return_and_config_load_decode dut (.CLK_SYS_I(clk), .RST_I(rst), .INSTR_I(instr),
        .STACK_TOP_I(stack_top), .W_I(w_acc), .IRQ_EN_CLR_I(en_clr),
        .CFG_FILE_WE_I(file_we), .CFG_FILE_WDATA_I(file_wdata), .PC_O(pc),
        .STACK_POP_O(pop), .INTERRUPT_CONTROL_REG_O(icr), .CFG_FILE_RDATA_O(cfg),
        .Q_PHASE_O(phase));
    prog_mem_model mem (.addr_i(pc), .instr_o(instr));

    initial begin
        forever #25 clk = ~clk;
    end

    // =====================================================================
    // Helpers
    // =====================================================================
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Runs to the negedge after the Q4 tick, noting pops and enable timing
    task automatic run_cycle;
        logic [1:0] p;
        pops = 0;
        p = phase;
        for (int k = 0; k < 20; k++) begin
            @(negedge clk);
            if (pop === 1'b1) pops++;
            if (phase === 2'd2) en_q2 = icr;
            if (phase === 2'd3 && p === 2'd2) en_q3 = icr;
            if (p === 2'd3 && phase === 2'd0) return;
            p = phase;
        end
        check("cycle_end", 16'h0, 16'h1);
    endtask

    // Safety net against a hung phase generator
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic test_nop;
        run_cycle();
        check("nop_pc", pc, 16'h1);
        check("nop_cfg", cfg, `CFG_RST);
        check("nop_pop", pops, 16'h0);
    endtask

    task automatic test_cfg_load;
        run_cycle();
        check("load_cfg", cfg, 16'h5a);
        check("load_pc", pc, 16'h2);
    endtask

    task automatic test_return;
        run_cycle();
        check("ret_en_q2", en_q2, 16'h0);
        check("ret_en_q3", en_q3, 16'h80);
        check("ret_pops", pops, 16'h1);
        check("ret_pc", pc, 16'h00a);
        check("ret_cfg", cfg, 16'h5a);
    endtask

    task automatic test_idle;
        w_acc = 8'h3c;
        run_cycle();
        check("idle_pops", pops, 16'h0);
        check("idle_cfg", cfg, 16'h5a);
        check("idle_pc", pc, 16'h00b);
        check("idle_icr", icr, 16'h80);
    endtask

    task automatic test_file_write;
        @(negedge clk);
        file_we = 1'b1;
        file_wdata = 8'ha5;
        @(negedge clk);
        file_we = 1'b0;
        check("file_rd", cfg, 16'ha5);
        run_cycle();
        check("file_keep", cfg, 16'ha5);
        check("file_pc", pc, 16'h00c);
    endtask

    // Clear held across a return: the Q3 set must win, the clear then takes over
    task automatic test_clear_race;
        stack_top = 13'h0003;
        en_clr = 1'b1;
        run_cycle();
        en_clr = 1'b0;
        check("race_en_q2", en_q2, 16'h0);
        check("race_en_q3", en_q3, 16'h80);
        check("race_icr", icr, 16'h0);
        check("race_pops", pops, 16'h1);
        check("race_pc", pc, 16'h003);
        run_cycle();
        check("race_idle_pops", pops, 16'h0);
        check("race_idle_pc", pc, 16'h004);
        check("race_idle_icr", icr, 16'h0);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check("rst_cfg", cfg, `CFG_RST);
        check("rst_pc", pc, `PC_RST);
        check("rst_phase", phase, 16'h0);
        check("rst_icr", icr, 16'h0);
        test_nop();
        test_cfg_load();
        test_return();
        test_idle();
        test_file_write();
        test_clear_race();
        report_and_stop();
    end
endmodule
